// ---- rtl/clock_gen_pkg.sv ----
package clock_gen_pkg;

  // special function register addresses
  localparam logic [7:0] TRIM_ADDR = 8'h96;
  localparam logic [7:0] DIVISOR_ADDR = 8'h9E;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field layout of the trim register
  localparam int TRIM_MSB = 5;
  localparam int TRIM_WIDTH = 6;
  localparam int CLKOUT_EN_BIT = 6;

  // divisor value after reset, and centre code of the trim range
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [5:0] TRIM_CENTER = 6'h20;

  // nonvolatile oscillator configuration codes
  localparam logic [2:0] CFG_XTAL_HIGH = 3'h0;
  localparam logic [2:0] CFG_XTAL_MED = 3'h1;
  localparam logic [2:0] CFG_XTAL_LOW = 3'h2;
  localparam logic [2:0] CFG_RC = 3'h3;
  localparam logic [2:0] CFG_WDT = 3'h4;
  localparam logic [2:0] CFG_EXT = 3'h7;

  // crystal amplifier range codes
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MED = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // timing
  localparam int CLK_MHZ = 50;
  localparam int WAKE_XTAL_OSC = 992;
  localparam int WAKE_OTHER_OSC = 224;
  localparam int WAKE_MIN_US = 60;
  localparam int WAKE_US_CYCLES = WAKE_MIN_US * CLK_MHZ;
  localparam int WDT_OSC_KHZ = 400;
  localparam int WDT_DIV = (CLK_MHZ * 1000) / WDT_OSC_KHZ;
  localparam int RC_NOMINAL_KHZ = 7373;
  localparam int RC_ACC_BITS = 16;
  localparam int RC_STEP_NOM = (RC_NOMINAL_KHZ * 65536 + CLK_MHZ * 500) / (CLK_MHZ * 1000);
  localparam int RC_STEP_TRIM = 48;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic osc;
    logic cpu;
    logic machine;
    logic periph;
  } clk_ticks_t;

endpackage

// ---- rtl/pin_edge_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    last_d = sync_q;
    if (!i_rst_n) begin
      meta_d = 1'b0;
      sync_d = 1'b0;
      last_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
    last_q <= last_d;
  end

  // only the second stage and its delayed copy feed the edge detect
  assign o_rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// ---- rtl/mcu_clock_generation.sv ----
// Function
// - one of four sources feeds divider
// - machine cycle is two cpu clocks
// - peripheral clock is cpu clock halved
// - internal rc oscillator nominally 7.373 MHz
// - source chosen by nonvolatile configuration bits
// - low crystal range 20 to 100 kHz
// - medium crystal range 100 kHz to 4 MHz
// - high crystal range 4 to 18 MHz
// - clock output only without crystal use
// - clock output only when enable bit set
// - clock output is half cpu clock
// - trim loaded only on power-on reset
// - trim register at 96H, bits 5:0
// - trim value tunes rc, rewritable anytime
// - divider up to 510, change anytime
// - wake-up delay 992 or 224 plus 60us
`timescale 1ns/100ps
`default_nettype none
module mcu_clock_generation #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic [2:0] i_osc_config,
  input wire logic [5:0] i_factory_trim,
  input wire logic i_xtal_pin,
  input wire logic i_ext_clk_pin,
  input wire logic i_rtc_on_crystal,
  input wire logic i_power_down,
  input wire clock_gen_pkg::sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output clock_gen_pkg::clk_ticks_t o_ticks,
  output logic [1:0] o_xtal_gain,
  output logic o_crystal_out_clock_pin,
  output logic o_crystal_out_clock_oe,
  output logic o_cpu_clock_running
);
  typedef enum logic [3:0] {
    ST_STOP = 4'h1,
    ST_WAKE_OSC = 4'h2,
    ST_WAKE_US = 4'h4,
    ST_RUN = 4'h8
  } wake_state_t;

  logic any_rst;
  assign any_rst = !i_rst_n || !i_por_n;

  logic xtal_rise;
  logic ext_rise;
  pin_edge_sync u_xtal_sync (
    .i_clk(i_clk),
    .i_rst_n(!any_rst),
    .i_pin(i_xtal_pin),
    .o_rise(xtal_rise)
  );
  pin_edge_sync u_ext_sync (
    .i_clk(i_clk),
    .i_rst_n(!any_rst),
    .i_pin(i_ext_clk_pin),
    .o_rise(ext_rise)
  );

  // configuration and registers
  logic [2:0] cfg_q, cfg_d;
  logic [5:0] trim_q, trim_d;
  logic clkout_en_q, clkout_en_d;
  logic [DIV_WIDTH-1:0] divisor_q, divisor_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    cfg_d = cfg_q;
    trim_d = trim_q;
    clkout_en_d = clkout_en_q;
    divisor_d = divisor_q;
    rdata_d = rdata_q;
    if (i_sfr.wr && i_sfr.addr == clock_gen_pkg::TRIM_ADDR) begin
      trim_d = i_sfr.wdata[clock_gen_pkg::TRIM_MSB:0];
      clkout_en_d = i_sfr.wdata[clock_gen_pkg::CLKOUT_EN_BIT];
    end
    if (i_sfr.wr && i_sfr.addr == clock_gen_pkg::DIVISOR_ADDR) begin
      divisor_d = i_sfr.wdata[DIV_WIDTH-1:0];
    end
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        clock_gen_pkg::TRIM_ADDR: rdata_d = {1'b0, clkout_en_q, trim_q};
        clock_gen_pkg::DIVISOR_ADDR: rdata_d = 8'(divisor_q);
        default: rdata_d = clock_gen_pkg::UNMAPPED_READ;
      endcase
    end
    if (any_rst) begin
      // the strap is sampled only while reset is held, never at run time
      cfg_d = i_osc_config;
      divisor_d = DIV_WIDTH'(clock_gen_pkg::DIVISOR_RESET);
      rdata_d = clock_gen_pkg::UNMAPPED_READ;
    end
    if (!i_por_n) begin
      trim_d = i_factory_trim;
      clkout_en_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    cfg_q <= cfg_d;
    trim_q <= trim_d;
    clkout_en_q <= clkout_en_d;
    divisor_q <= divisor_d;
    rdata_q <= rdata_d;
  end

  assign o_sfr_rdata = rdata_q;

  // source selection
  logic is_xtal;
  always_comb begin
    is_xtal = 1'b0;
    o_xtal_gain = clock_gen_pkg::GAIN_OFF;
    case (cfg_q)
      clock_gen_pkg::CFG_XTAL_LOW: begin
        is_xtal = 1'b1;
        o_xtal_gain = clock_gen_pkg::GAIN_LOW;
      end
      clock_gen_pkg::CFG_XTAL_MED: begin
        is_xtal = 1'b1;
        o_xtal_gain = clock_gen_pkg::GAIN_MED;
      end
      clock_gen_pkg::CFG_XTAL_HIGH: begin
        is_xtal = 1'b1;
        o_xtal_gain = clock_gen_pkg::GAIN_HIGH;
      end
      default: begin
        is_xtal = 1'b0;
        o_xtal_gain = clock_gen_pkg::GAIN_OFF;
      end
    endcase
  end

  // rc oscillator modelled as a phase accumulator steered by the trim value
  localparam int ACC = clock_gen_pkg::RC_ACC_BITS;
  logic [ACC:0] rc_acc_q, rc_acc_d;
  logic [ACC-1:0] rc_step;
  logic [7:0] wdt_cnt_q, wdt_cnt_d;
  logic rc_tick;
  logic wdt_tick;

  always_comb begin
    rc_step = ACC'(clock_gen_pkg::RC_STEP_NOM
        + (int'(trim_q) - int'(clock_gen_pkg::TRIM_CENTER)) * clock_gen_pkg::RC_STEP_TRIM);
    rc_acc_d = {1'b0, rc_acc_q[ACC-1:0]} + {1'b0, rc_step};
    wdt_cnt_d = (wdt_cnt_q == 8'(clock_gen_pkg::WDT_DIV - 1)) ? 8'h00 : wdt_cnt_q + 8'h01;
    if (any_rst) begin
      rc_acc_d = '0;
      wdt_cnt_d = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    rc_acc_q <= rc_acc_d;
    wdt_cnt_q <= wdt_cnt_d;
  end

  assign rc_tick = rc_acc_q[ACC];
  assign wdt_tick = (wdt_cnt_q == 8'(clock_gen_pkg::WDT_DIV - 1));

  logic osc_tick;
  always_comb begin
    case (cfg_q)
      clock_gen_pkg::CFG_RC: osc_tick = rc_tick;
      clock_gen_pkg::CFG_WDT: osc_tick = wdt_tick;
      clock_gen_pkg::CFG_EXT: osc_tick = ext_rise;
      default: osc_tick = is_xtal ? xtal_rise : 1'b0;
    endcase
  end

  // wake-up timer
  wake_state_t st_q, st_d;
  logic [9:0] osc_cnt_q, osc_cnt_d;
  logic [11:0] us_cnt_q, us_cnt_d;
  logic [9:0] osc_wait;

  always_comb begin
    osc_wait = is_xtal ? 10'(clock_gen_pkg::WAKE_XTAL_OSC - 1)
                       : 10'(clock_gen_pkg::WAKE_OTHER_OSC - 1);
    st_d = st_q;
    osc_cnt_d = osc_cnt_q;
    us_cnt_d = us_cnt_q;
    case (st_q)
      ST_STOP: begin
        osc_cnt_d = 10'h000;
        us_cnt_d = 12'h000;
        if (!i_power_down) begin
          st_d = ST_WAKE_OSC;
        end
      end
      ST_WAKE_OSC: begin
        if (osc_tick) begin
          osc_cnt_d = osc_cnt_q + 10'h001;
          if (osc_cnt_q == osc_wait) begin
            st_d = ST_WAKE_US;
          end
        end
      end
      ST_WAKE_US: begin
        us_cnt_d = us_cnt_q + 12'h001;
        if (us_cnt_q == 12'(clock_gen_pkg::WAKE_US_CYCLES - 1)) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_power_down) begin
          st_d = ST_STOP;
        end
      end
      default: st_d = ST_STOP;
    endcase
    if (any_rst) begin
      st_d = ST_WAKE_OSC;
      osc_cnt_d = 10'h000;
      us_cnt_d = 12'h000;
    end
  end

  always_ff @(posedge i_clk) begin
    st_q <= st_d;
    osc_cnt_q <= osc_cnt_d;
    us_cnt_q <= us_cnt_d;
  end

  // divider: factor is twice the divisor, zero passes the oscillator through
  logic [DIV_WIDTH:0] div_cnt_q, div_cnt_d;
  logic [DIV_WIDTH:0] div_last;
  logic cpu_tick;
  logic mphase_q, mphase_d;
  logic clkout_q, clkout_d;
  logic clkout_allowed;

  assign div_last = (divisor_q == '0) ? '0 : ({divisor_q, 1'b0} - 1'b1);
  // a count past the new limit ends at once, so a change never stalls the cpu
  assign cpu_tick = (st_q == ST_RUN) && osc_tick && (div_cnt_q >= div_last);
  assign clkout_allowed = !is_xtal && !i_rtc_on_crystal;

  always_comb begin
    div_cnt_d = div_cnt_q;
    if (osc_tick) begin
      div_cnt_d = (div_cnt_q >= div_last) ? '0 : div_cnt_q + 1'b1;
    end
    mphase_d = cpu_tick ? !mphase_q : mphase_q;
    clkout_d = 1'b0;
    if (clkout_en_q && clkout_allowed) begin
      clkout_d = cpu_tick ? !clkout_q : clkout_q;
    end
    if (any_rst) begin
      div_cnt_d = '0;
      mphase_d = 1'b0;
      clkout_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    div_cnt_q <= div_cnt_d;
    mphase_q <= mphase_d;
    clkout_q <= clkout_d;
  end

  logic machine_tick;
  logic periph_tick;
  assign machine_tick = cpu_tick && mphase_q;
  assign periph_tick = cpu_tick && mphase_q;
  // one driver for the whole struct, so no tool sees its members driven apart
  assign o_ticks = '{osc: osc_tick, cpu: cpu_tick,
                     machine: machine_tick, periph: periph_tick};
  // software should drop the enable before idle to save power
  assign o_crystal_out_clock_oe = clkout_en_q && clkout_allowed;
  assign o_crystal_out_clock_pin = clkout_q;
  assign o_cpu_clock_running = (st_q == ST_RUN);

  trim_por_a: assert property (@(posedge i_clk) !i_por_n |=> trim_q == $past(i_factory_trim))
    else $error("trim not loaded on power-on reset");
  trim_keep_a: assert property (@(posedge i_clk) i_por_n && !i_rst_n |=> $stable(trim_q))
    else $error("trim changed by non power-on reset");
  clkout_gate_a: assert property (@(posedge i_clk) disable iff (any_rst)
      o_crystal_out_clock_oe |-> clkout_en_q && !is_xtal && !i_rtc_on_crystal)
    else $error("clock output driven while not permitted");
  clkout_half_a: assert property (@(posedge i_clk) disable iff (any_rst)
      cpu_tick && o_crystal_out_clock_oe && $stable(o_crystal_out_clock_oe)
      |=> o_crystal_out_clock_pin != $past(o_crystal_out_clock_pin))
    else $error("clock output did not toggle on cpu tick");
  periph_half_a: assert property (@(posedge i_clk) disable iff (any_rst)
      o_ticks.cpu && !o_ticks.periph |=> mphase_q)
    else $error("peripheral tick not on every second cpu tick");
  clkout_idle_a: assert property (@(posedge i_clk) disable iff (any_rst)
      !o_crystal_out_clock_oe |=> !o_crystal_out_clock_pin)
    else $error("clock output level left high while not driven");
  machine_pair_a: assert property (@(posedge i_clk) disable iff (any_rst)
      o_ticks.machine |=> !mphase_q)
    else $error("machine cycle phase not restarted");
  cpu_gated_a: assert property (@(posedge i_clk) disable iff (any_rst)
      st_q != ST_RUN |-> !o_ticks.cpu)
    else $error("cpu clock during wake-up delay");
  wake_us_a: assert property (@(posedge i_clk) disable iff (any_rst)
      st_q == ST_WAKE_US && $past(st_q) == ST_WAKE_OSC
      |-> (st_q == ST_WAKE_US)[*8])
    else $error("microsecond wake-up phase cut short");
  div_pass_a: assert property (@(posedge i_clk) disable iff (any_rst)
      st_q == ST_RUN && divisor_q == '0 && osc_tick |-> cpu_tick)
    else $error("undivided oscillator tick lost");
  src_sel_a: assert property (@(posedge i_clk) disable iff (any_rst)
      cfg_q == clock_gen_pkg::CFG_WDT |-> osc_tick == wdt_tick)
    else $error("oscillator tick not from selected source");
endmodule
`default_nettype wire

// ---- verification/mcu_clock_generation_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcu_clock_generation_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_por_n = 1'b0;
  logic [2:0] i_osc_config = 3'h7;
  logic [5:0] i_factory_trim = 6'h2A;
  logic ph = 1'b0;
  logic i_rtc_on_crystal = 1'b0;
  logic i_power_down = 1'b0;
  clock_gen_pkg::sfr_req_t i_sfr = '0;
  logic [7:0] o_sfr_rdata;
  clock_gen_pkg::clk_ticks_t o_ticks;
  logic [1:0] o_xtal_gain;
  logic pin, oe, run;
  logic arm = 1'b0;
  logic seen, mseen, tog, pin_prev;
  int n_errors = 0, checked = 0, seed = 78904, cyc = 0, t = 0;
  int div_m = 0, trim_m = 0, en_m = 0, osc_n = 0, cpu_n = 0, g_n = 0;
  logic [2:0] cfgs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [1:0] gains [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};

  mcu_clock_generation dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
    .i_osc_config(i_osc_config), .i_factory_trim(i_factory_trim), .i_xtal_pin(ph),
    .i_ext_clk_pin(ph), .i_rtc_on_crystal(i_rtc_on_crystal), .i_power_down(i_power_down),
    .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .o_ticks(o_ticks), .o_xtal_gain(o_xtal_gain),
    .o_crystal_out_clock_pin(pin), .o_crystal_out_clock_oe(oe), .o_cpu_clock_running(run));

  always #10 i_clk = ~i_clk;

  // one oscillator source for both pins: a tick every PIN_CYC system cycles (12.5 MHz);
  // above 12 MHz the reset pin must be in use, which the bench's reset input stands for
  localparam int PIN_CYC = 4;
  // rise in rc rate when the trim goes from its centre to its top code
  localparam int RC_UP_KHZ = 31 * clock_gen_pkg::RC_STEP_TRIM * clock_gen_pkg::CLK_MHZ * 1000
      / (1 << clock_gen_pkg::RC_ACC_BITS);
  always @(posedge i_clk) begin
    #2;
    cyc = cyc + 1;
    if (cyc % (PIN_CYC / 2) == 0) ph = ~ph;
    if (cyc > 60000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic sfr(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    #2;
    i_sfr = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk);
    #2;
    i_sfr = '0;
  endtask

  task automatic rd(logic [7:0] a, int e, string nm);
    sfr(1'b0, a, 8'h00);
    chk(nm, e, o_sfr_rdata);
  endtask

  task automatic rst(logic por, logic [2:0] cfg);
    @(posedge i_clk);
    #2;
    i_osc_config = cfg;
    i_rst_n = 1'b0;
    i_por_n = !por;
    repeat (10) @(posedge i_clk);
    #2;
    i_rst_n = 1'b1;
    i_por_n = 1'b1;
    div_m = 0;
    if (por) begin
      trim_m = i_factory_trim;
      en_m = 0;
    end
  endtask

  // n is the oscillator tick count of the wake-up phase for the source in use
  task automatic wait_run(int n);
    int k;
    int lo;
    k = 0;
    lo = n * PIN_CYC + clock_gen_pkg::WAKE_US_CYCLES;
    while (run !== 1'b1 && k < 10000) begin
      @(posedge i_clk);
      #2;
      k++;
    end
    chk("running", 1, run);
    chk("wake delay", 1, k > lo - 16 && k < lo + 16);
  endtask

  // osc ticks in a fixed window, allowed one tick either way for the phase
  task automatic count_osc(int khz, string nm, output int c);
    int diff;
    c = 0;
    repeat (3000) begin
      @(negedge i_clk);
      if (o_ticks.osc === 1'b1) c++;
    end
    diff = c * clock_gen_pkg::CLK_MHZ * 1000 - 3000 * khz;
    chk(nm, 1, diff < clock_gen_pkg::CLK_MHZ * 1000 && diff > -clock_gen_pkg::CLK_MHZ * 1000);
  endtask

  task automatic meas(int d, int n);
    arm = 1'b0;
    sfr(1'b1, clock_gen_pkg::DIVISOR_ADDR, d[7:0]);
    div_m = d;
    rd(clock_gen_pkg::DIVISOR_ADDR, d, "divisor");
    arm = 1'b1;
    repeat (n) @(posedge i_clk);
    chk("cpu gaps measured", 1, g_n >= 2);
    chk("machine ticks seen", 1, mseen);
    arm = 1'b0;
    $display("test divide %0d done", d);
  endtask

  // model of the divider chain, checked where every tick settles
  always @(negedge i_clk) begin
    if (o_ticks.cpu === 1'b1 && run !== 1'b1) chk("tick while stopped", 0, 1);
    if (!arm) begin
      seen = 0;
      mseen = 0;
      tog = 0;
      g_n = 0;
      osc_n = 0;
    end else begin
      if (tog) chk("clock out toggle", !pin_prev, pin);
      tog = 0;
      if (o_ticks.osc === 1'b1) osc_n++;
      if (o_ticks.cpu === 1'b1) begin
        if (seen) chk("osc per cpu", div_m == 0 ? 1 : 2 * div_m, osc_n);
        g_n = g_n + seen;
        osc_n = 0;
        seen = 1;
        cpu_n++;
        tog = oe;
        pin_prev = pin;
        if (mseen) chk("machine tick", cpu_n == 2, o_ticks.machine);
        if (mseen) chk("periph tick", cpu_n == 2, o_ticks.periph);
        if (o_ticks.machine === 1'b1) begin
          mseen = 1;
          cpu_n = 0;
        end
      end else begin
        chk("machine idle", 0, o_ticks.machine);
        chk("periph idle", 0, o_ticks.periph);
      end
    end
  end

  initial begin
    int c1;
    int c2;
    rst(1'b1, 3'h7);
    rd(clock_gen_pkg::TRIM_ADDR, trim_m, "trim after power on");
    rd(clock_gen_pkg::DIVISOR_ADDR, 0, "divisor reset");
    rd(8'h55, 0, "unmapped read");
    t = $random(seed);
    sfr(1'b1, clock_gen_pkg::TRIM_ADDR, {2'b11, t[5:0]});
    sfr(1'b1, 8'h97, 8'hFF);
    trim_m = t[5:0];
    en_m = 1;
    rd(clock_gen_pkg::TRIM_ADDR, en_m * 64 + trim_m, "trim write");
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      i_rtc_on_crystal = (i == 5);
      rst(1'b0, cfgs[i]);
      repeat (3) @(posedge i_clk);
      #2;
      chk("crystal gain", gains[i], o_xtal_gain);
      chk("clock out enable", cfgs[i] >= 3 && i != 5, oe);
    end
    i_osc_config = 3'h0;
    repeat (4) @(posedge i_clk);
    #2;
    chk("config held after reset", 0, o_xtal_gain);
    i_rtc_on_crystal = 1'b0;
    rst(1'b0, 3'h7);
    rd(clock_gen_pkg::TRIM_ADDR, en_m * 64 + trim_m, "trim kept");
    $display("test source select done");
    wait_run(clock_gen_pkg::WAKE_OTHER_OSC);
    chk("clock out enable", 1, oe);
    meas(0, 200);
    t = $random(seed);
    meas(1 + t[1:0], 600);
    meas(255, 6500);
    // software drops the output enable before sleeping, to save power
    sfr(1'b1, clock_gen_pkg::TRIM_ADDR, trim_m[7:0]);
    en_m = 0;
    repeat (2) @(posedge i_clk);
    #2;
    chk("clock out disabled", 0, oe);
    i_power_down = 1'b1;
    repeat (5) @(posedge i_clk);
    #2;
    chk("stopped", 0, run);
    repeat (100) @(posedge i_clk);
    #2;
    i_power_down = 1'b0;
    wait_run(clock_gen_pkg::WAKE_OTHER_OSC);
    $display("test power down done");
    i_factory_trim = 6'h15;
    rst(1'b0, 3'h3);
    rd(clock_gen_pkg::TRIM_ADDR, en_m * 64 + trim_m, "trim kept");
    rst(1'b1, 3'h3);
    rd(clock_gen_pkg::TRIM_ADDR, 8'h15, "trim factory");
    $display("test trim reset done");
    sfr(1'b1, clock_gen_pkg::TRIM_ADDR, {2'b00, clock_gen_pkg::TRIM_CENTER});
    count_osc(clock_gen_pkg::RC_NOMINAL_KHZ, "rc rate", c1);
    sfr(1'b1, clock_gen_pkg::TRIM_ADDR, 8'h3F);
    count_osc(clock_gen_pkg::RC_NOMINAL_KHZ + RC_UP_KHZ, "rc trimmed rate", c2);
    chk("trim raises rc rate", 1, c2 > c1);
    rst(1'b0, clock_gen_pkg::CFG_WDT);
    count_osc(clock_gen_pkg::WDT_OSC_KHZ, "watchdog rate", c1);
    rst(1'b0, clock_gen_pkg::CFG_XTAL_HIGH);
    wait_run(clock_gen_pkg::WAKE_XTAL_OSC);
    count_osc(clock_gen_pkg::CLK_MHZ * 1000 / PIN_CYC, "crystal rate", c1);
    $display("test oscillator sources done");
    close_out();
  end
endmodule
`default_nettype wire
